// ===== design/memory_type_resolver_defines.vh
`ifndef MEMORY_TYPE_RESOLVER_DEFINES_VH
`define MEMORY_TYPE_RESOLVER_DEFINES_VH

// Memory-type encodings
`define MT_UC 3'h0
`define MT_WC 3'h1
`define MT_WT 3'h4
`define MT_WP 3'h5
`define MT_WB 3'h6
`define MT_UCM 3'h7

// Attribute table layout
`define PAT_SLOTS 8
`define PAT_SLOT_STRIDE 8
`define PAT_SLOT_W 3
`define PAT_RSVD_MASK 64'hF8F8F8F8F8F8F8F8
`define PAT_RESET 64'h0007040600070406

// Fixed-range registers cover addresses below this bound (1 Mbyte)
`define FIXED_RANGE_LIMIT 52'h0000000100000

`endif

// ===== design/overlap_combiner.v
`timescale 1ns/1ps
// Folds the types of all matching variable ranges into one type
module overlap_combiner #(
   parameter NUM_VAR = 8
) (
   input wire [NUM_VAR-1:0] hit,
   input wire [3*NUM_VAR-1:0] types,
   output reg [2:0] result,
   output reg any_hit,
   output reg defined
);
`include "memory_type_resolver_defines.vh"
   integer i;
   reg has_uc;
   reg has_wt;
   reg has_wb;
   reg has_other;
   reg same;
   reg [2:0] first;
   reg seen;
   always @* begin
      has_uc = 1'b0;
      has_wt = 1'b0;
      has_wb = 1'b0;
      has_other = 1'b0;
      same = 1'b1;
      first = `MT_UC;
      seen = 1'b0;
      for (i = 0; i < NUM_VAR; i = i + 1) begin
         if (hit[i]) begin
            if (!seen) begin
               first = types[3*i +: 3];
            end else if (types[3*i +: 3] != first) begin
               same = 1'b0;
            end
            seen = 1'b1;
            case (types[3*i +: 3])
               `MT_UC: has_uc = 1'b1;
               `MT_WT: has_wt = 1'b1;
               `MT_WB: has_wb = 1'b1;
               default: has_other = 1'b1;
            endcase
         end
      end
      any_hit = seen;
      defined = 1'b1;
      if (same) begin
         result = first;
      end else if (has_uc) begin
         result = `MT_UC;
      end else if (has_wt && has_wb && !has_other) begin
         result = `MT_WT;
      end else begin
         result = `MT_UC;
         defined = 1'b0;
      end
   end
endmodule // overlap_combiner

// ===== design/memory_type_resolver.v
`timescale 1ns/1ps
//Function
//- default table: page bits restrict range type
//- mixed ranges in large page: type unguaranteed
//- fixed ranges below 1 Mbyte win
//- identical overlapping variable types: use it
//- any uncacheable overlap gives uncacheable
//- only write_through and write_back gives write_through
//- other overlap mixes are undefined
//- software keeps settings identical across processors
//- table has eight 3-bit slots, rest reserved
//- slot encodings 0,1,4,5,6,7 supported
//- overridable uncacheable yields to write_combining range
//- reserved bits set: fault, table unchanged
//- unsupported slot encoding: fault, table unchanged
//- reset loads default slot values
//- uncacheable kinds: no cache, combine, speculation
//- write_combining: uncached, combine and speculate allowed
//- write_through: shared read fill, write through
//- write_protect: shared read fill, write hit invalidates
//- slot index is attr, cache_disable, write_through
//- defaults WB, WT, UC-, UC twice over
module memory_type_resolver #(
   parameter NUM_VAR = 8,
   parameter ADDR_W = 52
) (
   input wire sys_clk,
   input wire rst_b,
   input wire lookup_valid,
   input wire [ADDR_W-1:0] lookup_addr,
   input wire page_attribute,
   input wire page_cache_disable,
   input wire page_write_through,
   input wire fixed_hit,
   input wire [2:0] fixed_type,
   input wire [NUM_VAR-1:0] var_hit,
   input wire [3*NUM_VAR-1:0] var_type,
   input wire [2:0] default_type,
   input wire pat_wr_en,
   input wire [63:0] pat_wr_data,
   output reg [63:0] page_attribute_table_q,
   output reg pat_gp_fault_q,
   output reg result_valid_q,
   output reg [2:0] effective_type_q,
   output reg type_defined_q,
   output reg cacheable_q,
   output reg read_alloc_q,
   output reg read_alloc_excl_q,
   output reg write_alloc_q,
   output reg write_through_q,
   output reg write_hit_invalidate_q,
   output reg write_combine_q,
   output reg speculative_ok_q
);
`include "memory_type_resolver_defines.vh"

   wire [2:0] var_result;
   wire var_any;
   wire var_defined;
   reg [2:0] range_type;
   reg range_defined;
   reg [2:0] slot_type;
   reg [2:0] eff_d;
   reg def_d;
   wire [7:0] slot_bad;
   reg wr_bad;

   overlap_combiner #(
      .NUM_VAR(NUM_VAR)
   ) u_overlap (
      .hit(var_hit),
      .types(var_type),
      .result(var_result),
      .any_hit(var_any),
      .defined(var_defined)
   );

   // Range type: fixed ranges only in the lowest Mbyte, then variable, then default
   always @* begin
      if (fixed_hit && (lookup_addr < `FIXED_RANGE_LIMIT)) begin
         range_type = fixed_type;
         range_defined = 1'b1;
      end else if (var_any) begin
         range_type = var_result;
         range_defined = var_defined;
      end else begin
         range_type = default_type;
         range_defined = 1'b1;
      end
   end

   // Slot select from page bits
   always @* begin
      case ({page_attribute, page_cache_disable, page_write_through})
         3'h0: slot_type = page_attribute_table_q[2:0];
         3'h1: slot_type = page_attribute_table_q[10:8];
         3'h2: slot_type = page_attribute_table_q[18:16];
         3'h3: slot_type = page_attribute_table_q[26:24];
         3'h4: slot_type = page_attribute_table_q[34:32];
         3'h5: slot_type = page_attribute_table_q[42:40];
         3'h6: slot_type = page_attribute_table_q[50:48];
         3'h7: slot_type = page_attribute_table_q[58:56];
         default: slot_type = `MT_UC;
      endcase
   end

   // Combine page type with range type
   always @* begin
      eff_d = `MT_UC;
      def_d = range_defined;
      case (slot_type)
         `MT_UC: eff_d = `MT_UC;
         `MT_UCM: eff_d = (range_type == `MT_WC) ? `MT_WC : `MT_UC;
         `MT_WC: eff_d = `MT_WC;
         `MT_WP: begin
            if (range_type == `MT_WP || range_type == `MT_WB) begin
               eff_d = `MT_WP;
            end else begin
               eff_d = `MT_UC;
               def_d = def_d & (range_type == `MT_UC);
            end
         end
         `MT_WT: begin
            if (range_type == `MT_WT || range_type == `MT_WB) begin
               eff_d = `MT_WT;
            end else begin
               eff_d = `MT_UC;
               def_d = def_d & (range_type == `MT_UC);
            end
         end
         `MT_WB: eff_d = range_type;
         default: begin
            eff_d = `MT_UC;
            def_d = 1'b0;
         end
      endcase
   end

   // Write checks: reserved bits and unsupported encodings
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_chk
         wire [2:0] enc;
         assign enc = pat_wr_data[8*g +: 3];
         assign slot_bad[g] = ~((enc == `MT_UC) | (enc == `MT_WC) | (enc == `MT_WT) |
            (enc == `MT_WP) | (enc == `MT_WB) | (enc == `MT_UCM));
      end
   endgenerate

   always @* begin
      wr_bad = (|(pat_wr_data & `PAT_RSVD_MASK)) | (|slot_bad);
   end

   // Table keeps what software loads; no cross-processor
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         page_attribute_table_q <= `PAT_RESET;
         pat_gp_fault_q <= 1'b0;
      end else begin
         pat_gp_fault_q <= pat_wr_en & wr_bad;
         if (pat_wr_en && !wr_bad) begin
            page_attribute_table_q <= pat_wr_data;
         end
      end
   end

   // Registered result and cache policy
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         result_valid_q <= 1'b0;
         effective_type_q <= `MT_UC;
         type_defined_q <= 1'b0;
         cacheable_q <= 1'b0;
         read_alloc_q <= 1'b0;
         read_alloc_excl_q <= 1'b0;
         write_alloc_q <= 1'b0;
         write_through_q <= 1'b0;
         write_hit_invalidate_q <= 1'b0;
         write_combine_q <= 1'b0;
         speculative_ok_q <= 1'b0;
      end else begin
         result_valid_q <= lookup_valid;
         if (lookup_valid) begin
            effective_type_q <= eff_d;
            type_defined_q <= def_d;
            cacheable_q <= 1'b0;
            read_alloc_q <= 1'b0;
            read_alloc_excl_q <= 1'b0;
            write_alloc_q <= 1'b0;
            write_through_q <= 1'b1;
            write_hit_invalidate_q <= 1'b0;
            write_combine_q <= 1'b0;
            speculative_ok_q <= 1'b0;
            case (eff_d)
               `MT_WC: begin
                  write_combine_q <= 1'b1;
                  speculative_ok_q <= 1'b1;
               end
               `MT_WT: begin
                  cacheable_q <= 1'b1;
                  read_alloc_q <= 1'b1;
               end
               `MT_WP: begin
                  cacheable_q <= 1'b1;
                  read_alloc_q <= 1'b1;
                  write_hit_invalidate_q <= 1'b1;
               end
               `MT_WB: begin
                  cacheable_q <= 1'b1;
                  read_alloc_q <= 1'b1;
                  read_alloc_excl_q <= 1'b1;
                  write_alloc_q <= 1'b1;
                  write_through_q <= 1'b0;
               end
               default: begin
                  cacheable_q <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule // memory_type_resolver

// ===== test/cache_side_model.sv
`timescale 1ns/1ps
module cache_side_model (
   input logic sys_clk,
   input logic rst_b,
   input logic result_valid_q,
   output int n_got
);
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) n_got <= 0;
      else if (result_valid_q) n_got <= n_got + 1;
   end
endmodule // cache_side_model

// ===== test/mtr_asserts.sv
`timescale 1ns/1ps
`include "memory_type_resolver_defines.vh"
module mtr_asserts #(parameter NUM_VAR = 8, parameter ADDR_W = 52) (
   input logic sys_clk, rst_b, lookup_valid, fixed_hit, pat_wr_en, pat_gp_fault_q,
   input logic result_valid_q, cacheable_q, write_combine_q, speculative_ok_q,
   input logic [ADDR_W-1:0] lookup_addr,
   input logic [2:0] fixed_type, effective_type_q,
   input logic [NUM_VAR-1:0] var_hit,
   input logic [3*NUM_VAR-1:0] var_type,
   input logic [63:0] pat_wr_data, page_attribute_table_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire rsv = |(pat_wr_data & `PAT_RSVD_MASK);
   wire dft = page_attribute_table_q == `PAT_RESET;
   wire uc = effective_type_q == `MT_UC;
   logic bad;
   always_comb begin
      bad = 1'b0;
      for (int i = 0; i < 8; i++) bad |= pat_wr_data[8*i+1+:2] == 2'h1;
   end
   sequence s_kept; pat_gp_fault_q && $stable(page_attribute_table_q); endsequence
   property p_rst; $rose(rst_b) |-> dft; endproperty
   a_rst: assert property (p_rst) else $error("table not default");
   property p_rsv; pat_wr_en && rsv |=> s_kept; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved write");
   property p_enc; pat_wr_en && bad |=> s_kept; endproperty
   a_enc: assert property (p_enc) else $error("bad encoding");
   property p_ok; pat_wr_en && !rsv && !bad |=> page_attribute_table_q == $past(pat_wr_data);
   endproperty
   a_ok: assert property (p_ok) else $error("write lost");
   property p_fix; lookup_valid && dft && fixed_hit && fixed_type == 3'h0 &&
      lookup_addr < `FIXED_RANGE_LIMIT |=> uc; endproperty
   a_fix: assert property (p_fix) else $error("fixed lost");
   property p_uc; lookup_valid && dft && !fixed_hit && var_hit[0] && var_type[2:0] == 3'h0 |=> uc;
   endproperty
   a_uc: assert property (p_uc) else $error("overlap not uc");
   property p_pu; result_valid_q && uc |-> !(cacheable_q | write_combine_q | speculative_ok_q);
   endproperty
   a_pu: assert property (p_pu) else $error("uc policy");
   property p_pw; result_valid_q && effective_type_q == 3'h1 |-> write_combine_q && speculative_ok_q;
   endproperty
   a_pw: assert property (p_pw) else $error("wc policy");
   c_f: cover property (pat_gp_fault_q);
   c_w: cover property (result_valid_q && effective_type_q == 3'h1);
   c_t: cover property (result_valid_q && effective_type_q == 3'h4);
endmodule // mtr_asserts
bind memory_type_resolver mtr_asserts #(.NUM_VAR(NUM_VAR), .ADDR_W(ADDR_W)) u_chk (.*);

// ===== test/memory_type_resolver_tb.sv
`timescale 1ns/1ps
`include "memory_type_resolver_defines.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module memory_type_resolver_tb;
   logic sys_clk = 0, rst_b = 0, lookup_valid = 0, fixed_hit = 0, pat_wr_en = 0, u, d;
   logic page_attribute = 0, page_cache_disable = 0, page_write_through = 0;
   logic [51:0] lookup_addr = '0;
   logic [2:0] fixed_type = '0, default_type = '0, effective_type_q, e, m, p;
   logic [7:0] var_hit = '0;
   logic [23:0] var_type = '0;
   logic [63:0] pat_wr_data = '0, page_attribute_table_q, page_attribute_table, v;
   logic pat_gp_fault_q, result_valid_q, type_defined_q, cacheable_q, read_alloc_q;
   logic read_alloc_excl_q, write_alloc_q, write_through_q, write_hit_invalidate_q;
   logic write_combine_q, speculative_ok_q;
   wire [7:0] policy = {cacheable_q, read_alloc_q, read_alloc_excl_q, write_alloc_q,
      write_through_q, write_hit_invalidate_q, write_combine_q, speculative_ok_q};
   wire [13:0] outs = {result_valid_q, effective_type_q, type_defined_q, policy, pat_gp_fault_q};
   int checks = 0, n_mismatch = 0, nlook = 0, n_got, cyc = 0, seed = 64705;
   logic [2:0] tbl [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
   memory_type_resolver u_dut (.*);
   cache_side_model u_cache (.sys_clk, .rst_b, .result_valid_q, .n_got);
   initial forever #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (++cyc == 4000) begin n_mismatch++; wrap_up(); end
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   function automatic logic [2:0] pick(int n);
      return tbl[$unsigned($random(seed)) % n];
   endfunction
   function automatic logic [2:0] comb(logic [2:0] p, m);
      case (p)
         3'h1: comb = p;
         3'h4: comb = m[2] && !m[0] ? p : 3'h0;
         3'h5: comb = m == 3'h5 || m == 3'h6 ? p : 3'h0;
         3'h6: comb = m;
         3'h7: comb = m == 3'h1 ? m : 3'h0;
         default: comb = 3'h0;
      endcase
   endfunction
   // Policy bits: cacheable, read fill, exclusive fill, write fill, through, invalidate, wc, spec
   function automatic logic [7:0] pol(logic [2:0] t);
      case (t)
         3'h1: pol = 8'h0B;
         3'h4: pol = 8'hC8;
         3'h5: pol = 8'hCC;
         3'h6: pol = 8'hF0;
         default: pol = 8'h08;
      endcase
   endfunction
   function automatic logic [2:0] rng;
      logic [7:0] s;
      logic [2:0] t;
      s = '0;
      t = default_type;
      u = 0;
      if (fixed_hit && lookup_addr < `FIXED_RANGE_LIMIT) return fixed_type;
      for (int i = 0; i < 8; i++) if (var_hit[i]) begin t = var_type[3*i+:3]; s[t] = 1; end
      if (!(s & (s - 8'h1))) return t;
      if (s[0]) return 3'h0;
      if (s == 8'h50) return 3'h4;
      u = 1;
      return 3'h0;
   endfunction
   task run(int n);
      repeat (n) begin
         lookup_valid = 1;
         {page_attribute, page_cache_disable, page_write_through} = 3'($random(seed));
         fixed_hit = 1'($random(seed));
         lookup_addr = 21'($random(seed));
         var_hit = 8'($random(seed) & $random(seed));
         for (int i = 0; i < 8; i++) var_type[3*i+:3] = pick(5);
         fixed_type = pick(5);
         default_type = pick(5);
         m = rng();
         p = page_attribute_table[8*{page_attribute, page_cache_disable, page_write_through}+:3];
         e = comb(p, m);
         d = !u && !((p == 3'h4 || p == 3'h5) && e == 3'h0 && m != 3'h0);
         @(negedge sys_clk);
         nlook++;
         `CHK("type", e, effective_type_q)
         `CHK("defined", d, type_defined_q)
         `CHK("valid", 1'b1, result_valid_q)
         `CHK("policy", pol(e), policy)
      end
      lookup_valid = 0;
   endtask
   task wr(logic [63:0] d);
      logic f;
      f = |(d & `PAT_RSVD_MASK);
      for (int i = 0; i < 8; i++) f |= d[8*i+1+:2] == 2'h1;
      @(negedge sys_clk);
      pat_wr_en = 1;
      pat_wr_data = d;
      @(negedge sys_clk);
      pat_wr_en = 0;
      if (!f) page_attribute_table = d;
      `CHK("fault", f, pat_gp_fault_q)
      `CHK("table", page_attribute_table, page_attribute_table_q)
   endtask
   initial begin
      page_attribute_table = `PAT_RESET;
      repeat (3) @(negedge sys_clk);
      rst_b = 1;
      `CHK("reset", page_attribute_table, page_attribute_table_q)
      // Mixed ranges under one large page, page bits set most restrictive
      lookup_valid = 1;
      {page_attribute, page_cache_disable, page_write_through} = 3'h3;
      var_hit = 8'h03;
      var_type = 24'h00000C;
      @(negedge sys_clk);
      nlook++;
      `CHK("restrict", 3'h0, effective_type_q)
      run(40);
      $display("default table done");
      foreach (tbl[k]) begin
         wr({8{5'h0, tbl[k]}});
         run(8);
      end
      wr(page_attribute_table | 64'h80);
      wr(64'h0300000000000000);
      wr(64'h2);
      $display("encodings and faults done");
      repeat (10) begin
         for (int i = 0; i < 8; i++) v[8*i+:8] = {5'h0, pick(6)};
         wr(v);
         run(10);
      end
      @(negedge sys_clk);
      `CHK("results", nlook, n_got)
      $display("random done");
      rst_b = 0;
      @(negedge sys_clk);
      page_attribute_table = `PAT_RESET;
      nlook = 0;
      `CHK("reset outputs", 14'h0000, outs)
      `CHK("reset count", 0, n_got)
      rst_b = 1;
      `CHK("reset table", page_attribute_table, page_attribute_table_q)
      run(40);
      @(negedge sys_clk);
      `CHK("results after reset", nlook, n_got)
      $display("mid-run reset done");
      wrap_up();
   end
endmodule // memory_type_resolver_tb
